//--- rtl/ccs_clock_switch.v
// Clock source switch, sleep entry and peripheral gating with AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_map.vh"

module ccs_clock_switch (
  // Clock and reset.
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave.
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // System status and events.
  input  wire        power_good_status,
  input  wire        wake_event,
  input  wire        power_recover,
  input  wire        wake_keep_state,
  // Clock source and gating controls.
  output wire        cpu_osc_enable,
  output wire        cpu_pll_enable,
  output wire        meter_osc_enable,
  output wire        meter_pll_enable,
  output reg         pll_quick_enable,
  output wire        cpu_domain_clock_run,
  output wire        meter_domain_clock_run,
  output wire        display_domain_clock_run,
  output wire        fourth_domain_clock_run,
  output wire        analog_write_block,
  output wire        sleep_active,
  output wire        deep_sleep_active,
  output reg         system_reset_req,
  // Peripheral gates.
  output wire        pulse_width_clockgen_gate,
  output wire        general_serial_enable,
  output wire        port_group_ten_gate,
  output wire        port_group_nine_gate,
  output wire        port_groups_low_gate,
  output wire        extended_serial_two_gate,
  output wire        extended_serial_one_gate,
  output wire        first_timer_gate
);

  // --------------------------------------------------------------------
  // Local constants
  // --------------------------------------------------------------------
  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_DEEP  = 3'b100;
  localparam       DOM_CPU   = 0;
  localparam       DOM_METER = 1;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [1:0]  sel_req_q;      // Requested source per domain, 1 is PLL.
  reg  [1:0]  sel_act_q;      // Source actually driving each domain.
  reg  [1:0]  sel_gap_q;      // Both mux legs off during a change.
  reg         quick_wake_q;
  reg         quick_sleep_q;
  reg         meter_gate_q;
  reg         disp_gate_q;
  reg  [1:0]  sleep_fld_q;
  reg  [7:0]  periph_q;
  reg  [2:0]  pstate_q;
  reg  [2:0]  pstate_d;
  reg         wr_pend_q;
  reg         wr_csc_q;
  reg         wr_prc_q;
  reg  [7:0]  ctrl_rd;
  wire        addr_ok;
  wire        hit_csc;
  wire        hit_prc;
  wire [7:0]  wd;
  wire        wr_csc;
  wire        wr_prc;
  wire        cpu_idle_osc;
  wire        wake_now;

  // --------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------
  // The slave never stalls and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];
  assign hit_csc   = haddr[`CCS_ADDR_W-1:0] == `CCS_OFS_CLOCK_CTRL;
  assign hit_prc   = haddr[`CCS_ADDR_W-1:0] == `CCS_OFS_PERIPH_GATE;
  assign wd        = hwdata[7:0];
  assign wr_csc    = wr_pend_q & wr_csc_q;
  assign wr_prc    = wr_pend_q & wr_prc_q;

  // Clock switch register as software sees it; selects show the live
  // source, not the request, so a poll tells when a change is done.
  always @* begin
    ctrl_rd = 8'h00;
    ctrl_rd[`CCS_BIT_METER_SEL]   = sel_act_q[DOM_METER];
    ctrl_rd[`CCS_BIT_QUICK_WAKE]  = quick_wake_q;
    ctrl_rd[`CCS_BIT_QUICK_SLEEP] = quick_sleep_q;
    ctrl_rd[`CCS_BIT_METER_GATE]  = meter_gate_q;
    ctrl_rd[`CCS_BIT_DISP_GATE]   = disp_gate_q;
    ctrl_rd[`CCS_BIT_SLEEP_HI]    = sleep_fld_q[1];
    ctrl_rd[`CCS_BIT_SLEEP_LO]    = sleep_fld_q[0];
    ctrl_rd[`CCS_BIT_CPU_SEL]     = sel_act_q[DOM_CPU];
  end

  // Address phase capture; read data is registered here so it stands
  // in the data phase. Unmapped addresses read zero.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_csc_q  <= 1'b0;
      wr_prc_q  <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_csc_q  <= hit_csc;
      wr_prc_q  <= hit_prc;
      if (addr_ok & ~hwrite) begin
        if (hit_csc) begin
          hrdata <= {24'h00_0000, ctrl_rd};
        end else if (hit_prc) begin
          hrdata <= {24'h00_0000, periph_q};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Control register updates
  // --------------------------------------------------------------------
  assign wake_now = wake_event & (pstate_q != ST_RUN);

  // Hardware clears come first, so a write in the same cycle wins.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_req_q        <= 2'b00;
      quick_wake_q     <= 1'b0;
      quick_sleep_q    <= 1'b0;
      meter_gate_q     <= 1'b0;
      disp_gate_q      <= 1'b0;
      sleep_fld_q      <= `CCS_SLEEP_NONE;
      pll_quick_enable <= 1'b0;
      periph_q         <= `CCS_RST_PERIPH_GATE;
    end else begin
      if (wake_event | power_recover) begin
        quick_wake_q  <= 1'b0;
        quick_sleep_q <= 1'b0;
      end
      if (wake_now) begin
        sleep_fld_q <= `CCS_SLEEP_NONE;
      end
      if (wr_csc) begin
        // Select bits of the write are ignored while quick-wake holds the lock; a quick-sleep write still moves the CPU select.
        if (!quick_wake_q) begin
          sel_req_q[DOM_METER] <= wd[`CCS_BIT_METER_SEL];
          sel_req_q[DOM_CPU]   <= wd[`CCS_BIT_CPU_SEL];
        end
        meter_gate_q <= wd[`CCS_BIT_METER_GATE];
        disp_gate_q  <= wd[`CCS_BIT_DISP_GATE];
        sleep_fld_q  <= {wd[`CCS_BIT_SLEEP_HI], wd[`CCS_BIT_SLEEP_LO]};
        // Quick-wake is ignored entirely while quick-sleep is set.
        if (!quick_sleep_q) begin
          quick_wake_q <= wd[`CCS_BIT_QUICK_WAKE];
          if (wd[`CCS_BIT_QUICK_WAKE]) begin
            pll_quick_enable   <= 1'b1;
            sel_req_q[DOM_CPU] <= 1'b1;
          end
        end
        quick_sleep_q <= wd[`CCS_BIT_QUICK_SLEEP];
        if (wd[`CCS_BIT_QUICK_SLEEP]) begin
          sel_req_q[DOM_CPU] <= 1'b0;
          pll_quick_enable   <= 1'b0;
        end
      end
      if (wr_prc) begin
        periph_q <= wd;
      end
    end
  end

  // --------------------------------------------------------------------
  // Break-before-make source muxes, one per domain
  // --------------------------------------------------------------------
  // A change first turns both legs off for one cycle, then brings up
  // the new leg; the extra cycle costs latency but prevents runt pulses.
  genvar gd;
  generate
    for (gd = 0; gd < 2; gd = gd + 1) begin : g_dom
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sel_act_q[gd] <= 1'b0;
          sel_gap_q[gd] <= 1'b0;
        end else if (sel_gap_q[gd]) begin
          sel_act_q[gd] <= sel_req_q[gd];
          sel_gap_q[gd] <= 1'b0;
        end else if (sel_req_q[gd] != sel_act_q[gd]) begin
          sel_gap_q[gd] <= 1'b1;
        end
      end
    end
  endgenerate

  assign cpu_osc_enable   = ~sel_act_q[DOM_CPU] & ~sel_gap_q[DOM_CPU];
  assign cpu_pll_enable   = sel_act_q[DOM_CPU] & ~sel_gap_q[DOM_CPU];
  assign meter_osc_enable = ~sel_act_q[DOM_METER] & ~sel_gap_q[DOM_METER];
  assign meter_pll_enable = sel_act_q[DOM_METER] & ~sel_gap_q[DOM_METER];

  // Any domain on its way back to OSC shuts out analog writes.
  assign analog_write_block = |(sel_gap_q & sel_act_q);

  // --------------------------------------------------------------------
  // Power state machine
  // --------------------------------------------------------------------
  assign cpu_idle_osc = ~sel_req_q[DOM_CPU] & ~sel_act_q[DOM_CPU] &
                        ~sel_gap_q[DOM_CPU];

  // Sleep is only entered once the CPU domain really runs on OSC.
  always @* begin
    pstate_d = pstate_q;
    case (pstate_q)
      ST_RUN: begin
        if (!power_good_status && cpu_idle_osc) begin
          if (quick_sleep_q) begin
            pstate_d = ST_SLEEP;
          end else if (sleep_fld_q == `CCS_SLEEP_DEEP) begin
            pstate_d = ST_DEEP;
          end else if (sleep_fld_q != `CCS_SLEEP_NONE) begin
            pstate_d = ST_SLEEP;
          end
        end
      end
      ST_SLEEP, ST_DEEP: begin
        if (wake_event) begin
          pstate_d = ST_RUN;
        end
      end
      default: begin
        pstate_d = ST_RUN;
      end
    endcase
  end

  // Wakeup without keep-state asks the system for a full reset.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pstate_q         <= ST_RUN;
      system_reset_req <= 1'b0;
    end else begin
      pstate_q         <= pstate_d;
      system_reset_req <= wake_now & ~wake_keep_state;
    end
  end

  assign sleep_active      = pstate_q == ST_SLEEP;
  assign deep_sleep_active = pstate_q == ST_DEEP;

  // --------------------------------------------------------------------
  // Clock run enables
  // --------------------------------------------------------------------
  assign cpu_domain_clock_run    = pstate_q == ST_RUN;
  assign fourth_domain_clock_run = pstate_q == ST_RUN;
  assign meter_domain_clock_run  = ~meter_gate_q;
  // The display gate only bites with both domains settled on PLL.
  assign display_domain_clock_run =
    ~(disp_gate_q & cpu_pll_enable & meter_pll_enable);

  // --------------------------------------------------------------------
  // Peripheral gates
  // --------------------------------------------------------------------
  assign pulse_width_clockgen_gate = periph_q[7];
  assign general_serial_enable     = periph_q[6];
  assign port_group_ten_gate       = periph_q[5];
  assign port_group_nine_gate      = periph_q[4];
  assign port_groups_low_gate      = periph_q[3];
  assign extended_serial_two_gate  = periph_q[2];
  assign extended_serial_one_gate  = periph_q[1];
  assign first_timer_gate          = periph_q[0];

  // Size is never checked; every access acts on the low byte, so it steers nothing.
  wire unused_ok = &{1'b0, hsize, haddr[31:`CCS_ADDR_W], hwdata[31:8]};

endmodule // ccs_clock_switch

`default_nettype wire

//--- rtl/ccs_map.vh
// Register map, field positions and reset values of the clock switch block.
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// ----------------------------------------------------------------------
// Byte addresses on the AHB-Lite bus
// ----------------------------------------------------------------------
`define CCS_ADDR_W          14
`define CCS_OFS_CLOCK_CTRL  14'h0080
`define CCS_OFS_PERIPH_GATE 14'h2d00

// ----------------------------------------------------------------------
// Clock switch control fields
// ----------------------------------------------------------------------
`define CCS_BIT_METER_SEL   7
`define CCS_BIT_QUICK_WAKE  6
`define CCS_BIT_QUICK_SLEEP 5
`define CCS_BIT_METER_GATE  4
`define CCS_BIT_DISP_GATE   3
`define CCS_BIT_SLEEP_HI    2
`define CCS_BIT_SLEEP_LO    1
`define CCS_BIT_CPU_SEL     0

// Sleep field codes.
`define CCS_SLEEP_NONE      2'b00
`define CCS_SLEEP_DEEP      2'b10

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define CCS_RST_CLOCK_CTRL  8'h00
`define CCS_RST_PERIPH_GATE 8'h00
// Quick-wake PLL output frequency in hertz.
`define CCS_QUICK_PLL_HZ    3276800
// Longest source return time in OSC cycles.
`define CCS_SWITCH_CYCLES   1

`endif

//--- verif/ccs_clock_switch_monitor.sv
// Port checker for the clock switch block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// Checker
// ------------------------------------------------------------------
module ccs_clock_switch_monitor (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // System status and events.
  input wire logic power_good_status,
  input wire logic wake_event,
  input wire logic wake_keep_state,
  // Clock controls and state.
  input wire logic cpu_osc_enable,
  input wire logic cpu_pll_enable,
  input wire logic meter_osc_enable,
  input wire logic meter_pll_enable,
  input wire logic cpu_domain_clock_run,
  input wire logic display_domain_clock_run,
  input wire logic fourth_domain_clock_run,
  input wire logic analog_write_block,
  input wire logic sleep_active,
  input wire logic deep_sleep_active,
  input wire logic system_reset_req
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A wake request seen while either sleep state holds.
  sequence s_wake;
    (sleep_active || deep_sleep_active) ##0 wake_event;
  endsequence
  // Break-before-make: a runt pulse needs both legs on at once.
  chk_cpu_legs:
    assert property (!(cpu_osc_enable && cpu_pll_enable))
    else $error("cpu mux legs both on");
  chk_meter_legs:
    assert property (!(meter_osc_enable && meter_pll_enable))
    else $error("meter mux legs both on");
  chk_sleep_stops:
    assert property ((sleep_active || deep_sleep_active) |->
      !cpu_domain_clock_run && !fourth_domain_clock_run)
    else $error("cpu or fourth clock runs while asleep");
  chk_sleep_excl:
    assert property (!(sleep_active && deep_sleep_active))
    else $error("sleep and deep sleep together");
  chk_sleep_power:
    assert property (($rose(sleep_active) || $rose(deep_sleep_active))
      |-> !$past(power_good_status))
    else $error("sleep entered with power good");
  chk_wake_run:
    assert property (s_wake |=> !sleep_active && !deep_sleep_active
      && cpu_domain_clock_run)
    else $error("wake did not return to run");
  chk_wake_reset:
    assert property (s_wake |=> system_reset_req == !$past(wake_keep_state))
    else $error("reset request wrong on wake");
  chk_disp_gate:
    assert property (!display_domain_clock_run |->
      cpu_pll_enable && meter_pll_enable)
    else $error("display clock stopped off PLL");
  chk_gap_block:
    assert property (analog_write_block |->
      (!cpu_osc_enable && !cpu_pll_enable) ||
      (!meter_osc_enable && !meter_pll_enable))
    else $error("analog block outside a gap");
  // A gap that starts with the PLL leg just turned off is a return to OSC.
  // The block must then be raised, or writes could land mid-switch.
  sequence s_leave_pll;
    ($past(cpu_pll_enable) && !cpu_pll_enable && !cpu_osc_enable) ||
    ($past(meter_pll_enable) && !meter_pll_enable && !meter_osc_enable);
  endsequence
  chk_gap_raise:
    assert property (s_leave_pll |-> analog_write_block)
    else $error("analog writes open while leaving PLL");
endmodule // ccs_clock_switch_monitor

bind ccs_clock_switch ccs_clock_switch_monitor i_mon (
  .hclk(hclk), .hresetn(hresetn), .power_good_status(power_good_status),
  .wake_event(wake_event), .wake_keep_state(wake_keep_state),
  .cpu_osc_enable(cpu_osc_enable), .cpu_pll_enable(cpu_pll_enable),
  .meter_osc_enable(meter_osc_enable), .meter_pll_enable(meter_pll_enable),
  .cpu_domain_clock_run(cpu_domain_clock_run),
  .display_domain_clock_run(display_domain_clock_run),
  .fourth_domain_clock_run(fourth_domain_clock_run),
  .analog_write_block(analog_write_block), .sleep_active(sleep_active),
  .deep_sleep_active(deep_sleep_active), .system_reset_req(system_reset_req)
);
`default_nettype wire

//--- verif/ccs_clock_switch_tb.sv
// Self-checking bench for the clock switch block.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_map.vh"
`define CCS_CMP(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); \
  end end
module ccs_clock_switch_tb;
  localparam logic [13:0] cc_a = `CCS_OFS_CLOCK_CTRL;
  localparam logic [13:0] pg_a = `CCS_OFS_PERIPH_GATE;
  logic        hclk, hresetn, hsel, hwrite, pg, wk, pr, ks, obs;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata;
  logic [32:0] exp_q[$], ex;
  logic [7:0]  pgv, d;
  logic [7:0]  sc[4] = '{8'h20, 8'h02, 8'h06, 8'h04};
  int          bad_count, comparisons, i;
  wire         hro, hresp;
  wire  [31:0] hrdata;
  wire  [11:0] st;
  wire  [7:0]  pgo;
  // Status order: legs, quick PLL, run flags, sleep, deep, reset request.
  ccs_clock_switch i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hro), .hreadyout(hro), .hresp(hresp),
    .hrdata(hrdata), .power_good_status(pg), .wake_event(wk),
    .power_recover(pr), .wake_keep_state(ks), .cpu_osc_enable(st[11]),
    .cpu_pll_enable(st[10]), .meter_osc_enable(st[9]),
    .meter_pll_enable(st[8]), .pll_quick_enable(st[7]),
    .cpu_domain_clock_run(st[6]), .meter_domain_clock_run(st[5]),
    .display_domain_clock_run(st[4]), .fourth_domain_clock_run(st[3]),
    .analog_write_block(), .sleep_active(st[2]),
    .deep_sleep_active(st[1]), .system_reset_req(st[0]),
    .pulse_width_clockgen_gate(pgo[7]), .general_serial_enable(pgo[6]),
    .port_group_ten_gate(pgo[5]), .port_group_nine_gate(pgo[4]),
    .port_groups_low_gate(pgo[3]), .extended_serial_two_gate(pgo[2]),
    .extended_serial_one_gate(pgo[1]), .first_timer_gate(pgo[0]));
  // ----------------------------------------------------------------
  // Clock, bus tasks and observer
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // One single transfer; a read raises obs for its data phase.
  task automatic xfer(input logic [13:0] a, input logic w, logic [7:0] v);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {18'h0_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hro !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, v};
    obs    <= !w;
    do @(posedge hclk); while (hro !== 1'b1);
    obs <= 1'b0;
  endtask
  // Writes wait out the gap cycle before anything reads back.
  task automatic wr(input logic [13:0] a, input logic [7:0] v);
    xfer(a, 1'b1, v);
    repeat (3) @(posedge hclk);
  endtask
  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    exp_q.push_back({1'b0, 24'h00_0000, e});
    xfer(a, 1'b0, 8'h00);
  endtask
  // Samples the ports for one cycle and ends any event pulse.
  task automatic probe(input logic [11:0] e);
    exp_q.push_back({1'b1, 12'h000, e, pgv});
    @(posedge hclk);
    obs <= 1'b1;
    wk  <= 1'b0;
    pr  <= 1'b0;
    @(posedge hclk);
    obs <= 1'b0;
  endtask
  // Oldest note is compared when a result is presented.
  always @(posedge hclk) begin
    if (obs === 1'b1 && exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      if (ex[32]) `CCS_CMP("ports", ex[31:0], {12'h000, st, pgo})
      else `CCS_CMP("hrdata", ex[31:0], hrdata)
    end
  end
  task automatic give_verdict;
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cut a hang short well beyond the few hundred cycles needed.
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {wk, pr, obs, pgv} = '0;
    {pg, ks} = 2'b11;
    void'($urandom(34592));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(cc_a, 8'h00);
    rd(pg_a, 8'h00);
    probe(12'hA78);
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom());
      wr(pg_a, d);
      pgv = d;
      rd(pg_a, d);
      probe(12'hA78);
    end
    rd(14'h0004, 8'h00);
    wr(cc_a, 8'h01);
    rd(cc_a, 8'h01);
    wr(cc_a, 8'h09);
    probe(12'h678);
    wr(cc_a, 8'h89);
    rd(cc_a, 8'h89);
    probe(12'h568);
    wr(cc_a, 8'h91);
    probe(12'h558);
    wr(cc_a, 8'h00);
    rd(cc_a, 8'h00);
    wr(cc_a, 8'h40);
    rd(cc_a, 8'h41);
    probe(12'h6F8);
    wr(cc_a, 8'hC0);
    rd(cc_a, 8'h41);
    wr(cc_a, 8'h00);
    rd(cc_a, 8'h01);
    wr(cc_a, 8'h00);
    wr(cc_a, 8'h20);
    rd(cc_a, 8'h20);
    probe(12'hA78);
    wr(cc_a, 8'h60);
    rd(cc_a, 8'h20);
    pr <= 1'b1;
    probe(12'hA78);
    rd(cc_a, 8'h00);
    pg <= 1'b0;
    // Quick sleep and each sleep code, then wake with random keep.
    for (i = 0; i < 4; i++) begin
      wr(cc_a, sc[i]);
      probe(sc[i] == 8'h04 ? 12'hA32 : 12'hA34);
      ks <= 1'($urandom());
      @(posedge hclk);
      wk <= 1'b1;
      probe({11'h53C, !ks});
      rd(cc_a, 8'h00);
    end
    give_verdict();
  end
endmodule // ccs_clock_switch_tb
`default_nettype wire
